//--- rtl/bdc_pkg.sv
// shared constants for the bridge driver control register bank
package bdc_pkg;
  localparam logic [5:0] ADDR_STAT_1   = 6'h00;
  localparam logic [5:0] ADDR_STAT_2   = 6'h02;
  localparam logic [5:0] ADDR_DEV_CTL  = 6'h04;
  localparam logic [5:0] ADDR_BRG_CTL  = 6'h05;
  localparam logic [5:0] ADDR_HS_GATE  = 6'h06;
  localparam logic [5:0] ADDR_LS_GATE  = 6'h07;
  localparam logic [5:0] ADDR_GATE_MON = 6'h08;
  localparam logic [5:0] ADDR_OC_CFG   = 6'h09;
  localparam logic [5:0] ADDR_OC_LVL   = 6'h0a;
  localparam logic [5:0] ADDR_OFF_DIAG = 6'h0b;
  localparam logic [5:0] ADDR_SUPPLY   = 6'h0c;
  localparam logic [5:0] ADDR_SHUNT    = 6'h0d;
  localparam logic [5:0] ADDR_LAST     = 6'h0d;
  localparam logic [7:0] RST_DEV_CTL  = 8'h06;
  localparam logic [7:0] RST_BRG_CTL  = 8'h00;
  localparam logic [7:0] RST_HS_GATE  = 8'hff;
  localparam logic [7:0] RST_LS_GATE  = 8'hff;
  localparam logic [7:0] RST_GATE_MON = 8'h20;
  localparam logic [7:0] RST_OC_CFG   = 8'h20;
  localparam logic [7:0] RST_OC_LVL   = 8'hdd;
  localparam logic [7:0] RST_OFF_DIAG = 8'h80;
  localparam logic [7:0] RST_SUPPLY   = 8'h14;
  localparam logic [7:0] RST_SHUNT    = 8'h01;
  localparam logic [2:0] LOCK_OPEN    = 3'h3;
  localparam logic [2:0] LOCK_SHUT    = 3'h6;
  localparam int         BIT_OUTS_ON  = 7;
  localparam int         BIT_SPREAD   = 6;
  localparam int         BIT_SRC_ONE  = 5;
  localparam int         BIT_SRC_TWO  = 4;
  localparam int         LOCK_LSB     = 1;
  localparam int         BIT_CLR      = 0;
  localparam int         BIT_HS_OFF   = 7;
  localparam int         MODE_LSB     = 5;
  localparam int         BIT_FW       = 4;
  localparam int         BIT_SIN_ONE  = 3;
  localparam int         BIT_SIN_TWO  = 2;
  localparam int         BIT_FLT_ONE  = 1;
  localparam int         BIT_FLT_TWO  = 0;
  localparam int         BIT_IND      = 0;
  localparam int         BIT_CMP_LVL  = 1;
  localparam int         BIT_LIMP     = 7;
  localparam int         FRAME_BITS   = 16;
  localparam int         BIT_RW       = 14;
  localparam logic [4:0] FRAME_BITS_W = 5'h10;
  localparam logic [1:0] MODE_INDEP   = 2'h0;
  localparam logic [1:0] MODE_SPLIT   = 2'h3;
endpackage : bdc_pkg

//--- rtl/bdc_regs.sv
// control register bank with serial frame slave for the bridge driver
module bdc_regs (
  input  wire logic       CLK_SYS,
  input  wire logic       RST_B,
  input  wire logic       SCLK,
  input  wire logic       CS_B,
  input  wire logic       SDI,
  output logic            SDO,
  input  wire logic       BRIDGE_INPUT_ONE,
  input  wire logic       BRIDGE_INPUT_TWO,
  input  wire logic       FLOAT_PIN_ONE,
  input  wire logic       FLOAT_PIN_TWO,
  output logic            GATE_OUTPUTS_ON,
  output logic            SPREAD_CLOCK_OFF,
  output logic            INPUT_ONE,
  output logic            INPUT_TWO,
  output logic            FLOAT_ONE,
  output logic            FLOAT_TWO,
  output logic            HANDSHAKE_OFF,
  output logic [1:0]      BRIDGE_INPUT_SCHEME,
  output logic            FREEWHEEL_SIDE,
  output logic [3:0]      HS_SOURCE_CURRENT,
  output logic [3:0]      HS_SINK_CURRENT,
  output logic [3:0]      LS_SOURCE_CURRENT,
  output logic [3:0]      LS_SINK_CURRENT,
  output logic [1:0]      GATE_FAULT_RESPONSE,
  output logic [1:0]      DRIVE_AND_BLANK_TIME,
  output logic [2:0]      ADDED_DEAD_TIME,
  output logic            GATE_PER_HALF_SHUTDOWN,
  output logic [1:0]      OVERCURRENT_RESPONSE,
  output logic [1:0]      OVERCURRENT_FILTER_TIME,
  output logic [1:0]      POST_FAULT_PULLDOWN,
  output logic            GATE_COMPARE_LEVEL,
  output logic            OC_PER_HALF_SHUTDOWN,
  output logic [3:0]      HS_OVERCURRENT_LEVEL,
  output logic [3:0]      LS_OVERCURRENT_LEVEL,
  output logic            LIMP_HOME_SEL,
  output logic            CLEAR_LATCHED_FAULTS,
  output logic            FRAME_LENGTH_FAULT,
  output logic            BAD_ADDRESS_FAULT
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_APPLY = 3'b010,
    ST_CLEAR = 3'b100
  } bdc_state_t;

  // register index valid for the control range
  function automatic logic is_ctrl(input logic [5:0] a);
    is_ctrl = (a >= bdc_pkg::ADDR_DEV_CTL) && (a <= bdc_pkg::ADDR_LAST);
  endfunction : is_ctrl

  function automatic logic is_valid(input logic [5:0] a);
    is_valid = a <= bdc_pkg::ADDR_LAST;
  endfunction : is_valid

  // ---------------- link domain (serial clock) ----------------
  logic [15:0] sh_q;
  logic [4:0]  cnt_q;
  logic [7:0]  tx_q;
  logic [15:0] frame_q;
  logic [4:0]  len_q;
  logic        done_tgl_q;
  logic [7:0]  rd_sync1_q [16];
  logic [7:0]  rd_sync2_q [16];
  logic [7:0]  rd_mux;
  logic [5:0]  rx_addr;
  // readback words, built in the system domain below
  logic [7:0]  rd_word [16];

  // first-stage address of frame comes from bits shifted so far
  assign rx_addr = sh_q[5:0];
  always_comb
  begin
    rd_mux = 8'h00;
    if (is_valid(rx_addr))
      rd_mux = rd_sync2_q[rx_addr[3:0]];
  end

  // register snapshot resynchronised onto the serial clock; values
  // are quasi-static so a word rarely straddles an edge
  always_ff @(posedge SCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      for (int i = 0; i < 16; i++)
      begin
        rd_sync1_q[i] <= 8'h00;
        rd_sync2_q[i] <= 8'h00;
      end
    end
    else
    begin
      for (int i = 0; i < 16; i++)
      begin
        rd_sync1_q[i] <= rd_word[i];
        rd_sync2_q[i] <= rd_sync1_q[i];
      end
    end
  end

  // shift in on falling edge, msb first; count frame bits
  always_ff @(negedge SCLK or posedge CS_B)
  begin
    if (CS_B)
    begin
      sh_q  <= 16'h0000;
      cnt_q <= 5'h00;
    end
    else
    begin
      sh_q <= {sh_q[14:0], SDI};
      if (cnt_q != 5'h1f)
        cnt_q <= cnt_q + 5'h01;
    end
  end

  // shift out on rising edge: status byte then register contents;
  // first edge only presents the msb loaded while select was high
  always_ff @(posedge SCLK or posedge CS_B)
  begin
    if (CS_B)
      tx_q <= 8'hc0;
    else if (cnt_q == 5'h08)
      tx_q <= rd_mux;
    else if (cnt_q != 5'h00)
      tx_q <= {tx_q[6:0], 1'b0};
  end

  // pin taken straight from the shifter flop, no decode glitches
  assign SDO = tx_q[7];

  // capture frame at chip-select rise; toggle tells system domain
  always_ff @(posedge CS_B or negedge RST_B)
  begin
    if (!RST_B)
    begin
      frame_q    <= 16'h0000;
      len_q      <= 5'h00;
      done_tgl_q <= 1'b0;
    end
    else
    begin
      frame_q    <= sh_q;
      len_q      <= cnt_q;
      done_tgl_q <= ~done_tgl_q;
    end
  end

  // ---------------- system domain ----------------
  logic [2:0]  tgl_sync_q;
  logic [15:0] fr_q;
  logic [4:0]  ln_q;
  logic [7:0]  dev_q, brg_q, hsg_q, lsg_q, mon_q, ocf_q, ocl_q;
  logic [7:0]  off_q, sup_q, shu_q;
  logic        len_flt_q, bad_address_fault_q;
  logic        p1_q, p2_q, f1_q, f2_q, p1s_q, p2s_q, f1s_q, f2s_q;
  bdc_state_t  st_q;
  logic        frame_ev, wr_ok, locked, good_len;
  logic [5:0]  w_addr;
  logic [7:0]  w_data;

  // toggle edge means a completed frame; data is stable by then
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      tgl_sync_q <= 3'h0;
      fr_q       <= 16'h0000;
      ln_q       <= 5'h00;
    end
    else
    begin
      tgl_sync_q <= {tgl_sync_q[1:0], done_tgl_q};
      fr_q       <= frame_q;
      ln_q       <= len_q;
    end
  end

  assign frame_ev = tgl_sync_q[2] ^ tgl_sync_q[1];
  assign good_len = ln_q == bdc_pkg::FRAME_BITS_W;
  assign w_addr   = fr_q[13:8];
  assign w_data   = fr_q[7:0];
  assign locked   = dev_q[3:1] == bdc_pkg::LOCK_SHUT;
  assign wr_ok    = frame_ev && good_len && !fr_q[bdc_pkg::BIT_RW] &&
                    is_ctrl(w_addr);

  // sequencer: idle, fault clear pulse, then apply returns the clear bit to zero
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      st_q <= ST_IDLE;
    else
    begin
      case (st_q)
        ST_IDLE:  st_q <= (wr_ok && w_addr == bdc_pkg::ADDR_DEV_CTL &&
                           w_data[bdc_pkg::BIT_CLR]) ? ST_CLEAR : ST_IDLE;
        ST_CLEAR: st_q <= ST_APPLY;
        ST_APPLY: st_q <= ST_IDLE;
        default:  st_q <= ST_IDLE;
      endcase
    end
  end

  // control registers; defaults at reset, lock gates all but lock
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      dev_q <= bdc_pkg::RST_DEV_CTL;
      brg_q <= bdc_pkg::RST_BRG_CTL;
      hsg_q <= bdc_pkg::RST_HS_GATE;
      lsg_q <= bdc_pkg::RST_LS_GATE;
      mon_q <= bdc_pkg::RST_GATE_MON;
      ocf_q <= bdc_pkg::RST_OC_CFG;
      ocl_q <= bdc_pkg::RST_OC_LVL;
      off_q <= bdc_pkg::RST_OFF_DIAG;
      sup_q <= bdc_pkg::RST_SUPPLY;
      shu_q <= bdc_pkg::RST_SHUNT;
    end
    else
    begin
      if (st_q == ST_APPLY)
        dev_q[bdc_pkg::BIT_CLR] <= 1'b0;
      if (wr_ok)
      begin
        if (w_addr == bdc_pkg::ADDR_DEV_CTL)
        begin
          if (w_data[3:1] == bdc_pkg::LOCK_OPEN ||
              w_data[3:1] == bdc_pkg::LOCK_SHUT)
            dev_q[3:1] <= w_data[3:1];
          if (!locked)
          begin
            dev_q[7:4] <= w_data[7:4];
            dev_q[0]   <= w_data[0];
          end
        end
        else if (!locked)
        begin
          case (w_addr)
            bdc_pkg::ADDR_BRG_CTL:  brg_q <= w_data;
            bdc_pkg::ADDR_HS_GATE:  hsg_q <= w_data;
            bdc_pkg::ADDR_LS_GATE:  lsg_q <= w_data;
            bdc_pkg::ADDR_GATE_MON: mon_q <= w_data;
            bdc_pkg::ADDR_OC_CFG:   ocf_q <= w_data;
            bdc_pkg::ADDR_OC_LVL:   ocl_q <= w_data;
            bdc_pkg::ADDR_OFF_DIAG: off_q <= {w_data[7], 2'b00, w_data[4:0]};
            bdc_pkg::ADDR_SUPPLY:   sup_q <= w_data;
            bdc_pkg::ADDR_SHUNT:    shu_q <= w_data;
            default:                ;
          endcase
        end
      end
    end
  end

  // frame faults: set wins over the clear pulse
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      len_flt_q  <= 1'b0;
      bad_address_fault_q <= 1'b0;
    end
    else
    begin
      if (frame_ev && !good_len)
        len_flt_q <= 1'b1;
      else if (st_q == ST_CLEAR)
        len_flt_q <= 1'b0;
      if (frame_ev && good_len && !is_valid(w_addr))
        bad_address_fault_q <= 1'b1;
      else if (st_q == ST_CLEAR)
        bad_address_fault_q <= 1'b0;
    end
  end

  // readback words by index
  always_comb
  begin
    for (int i = 0; i < 16; i++)
      rd_word[i] = 8'h00;
    rd_word[0]  = {~(len_flt_q | bad_address_fault_q), 7'h00};
    rd_word[2]  = {6'h00, len_flt_q, bad_address_fault_q};
    rd_word[4]  = dev_q;
    rd_word[5]  = brg_q;
    rd_word[6]  = hsg_q;
    rd_word[7]  = lsg_q;
    rd_word[8]  = mon_q;
    rd_word[9]  = ocf_q;
    rd_word[10] = ocl_q;
    rd_word[11] = off_q;
    rd_word[12] = sup_q;
    rd_word[13] = shu_q;
  end

  // pins from outside pass two flops first
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      {p1_q, p2_q, f1_q, f2_q}     <= 4'h0;
      {p1s_q, p2s_q, f1s_q, f2s_q} <= 4'h0;
    end
    else
    begin
      {p1_q, p2_q, f1_q, f2_q} <= {BRIDGE_INPUT_ONE, BRIDGE_INPUT_TWO,
                                   FLOAT_PIN_ONE, FLOAT_PIN_TWO};
      {p1s_q, p2s_q, f1s_q, f2s_q} <= {p1_q, p2_q, f1_q, f2_q};
    end
  end

  // registered outputs derived from control fields, synchronised pins, fault flags and the sequencer
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      {GATE_OUTPUTS_ON, SPREAD_CLOCK_OFF, INPUT_ONE, INPUT_TWO} <= 4'h0;
      {FLOAT_ONE, FLOAT_TWO, HANDSHAKE_OFF, FREEWHEEL_SIDE}     <= 4'h0;
      BRIDGE_INPUT_SCHEME     <= 2'h0;
      {HS_SOURCE_CURRENT, HS_SINK_CURRENT} <= bdc_pkg::RST_HS_GATE;
      {LS_SOURCE_CURRENT, LS_SINK_CURRENT} <= bdc_pkg::RST_LS_GATE;
      {GATE_FAULT_RESPONSE, DRIVE_AND_BLANK_TIME} <=
        bdc_pkg::RST_GATE_MON[7:4];
      ADDED_DEAD_TIME         <= 3'h0;
      GATE_PER_HALF_SHUTDOWN  <= 1'b0;
      {OVERCURRENT_RESPONSE, OVERCURRENT_FILTER_TIME} <=
        bdc_pkg::RST_OC_CFG[7:4];
      POST_FAULT_PULLDOWN     <= 2'h0;
      GATE_COMPARE_LEVEL      <= 1'b0;
      OC_PER_HALF_SHUTDOWN    <= 1'b0;
      {HS_OVERCURRENT_LEVEL, LS_OVERCURRENT_LEVEL} <= bdc_pkg::RST_OC_LVL;
      LIMP_HOME_SEL           <= 1'b1;
      CLEAR_LATCHED_FAULTS    <= 1'b0;
      FRAME_LENGTH_FAULT      <= 1'b0;
      BAD_ADDRESS_FAULT       <= 1'b0;
    end
    else
    begin
      GATE_OUTPUTS_ON  <= dev_q[bdc_pkg::BIT_OUTS_ON];
      SPREAD_CLOCK_OFF <= dev_q[bdc_pkg::BIT_SPREAD];
      INPUT_ONE <= dev_q[bdc_pkg::BIT_SRC_ONE] ?
                   brg_q[bdc_pkg::BIT_SIN_ONE] : p1s_q;
      INPUT_TWO <= dev_q[bdc_pkg::BIT_SRC_TWO] ?
                   brg_q[bdc_pkg::BIT_SIN_TWO] : p2s_q;
      FLOAT_ONE <= (brg_q[6:5] == bdc_pkg::MODE_INDEP) &&
                   (brg_q[bdc_pkg::BIT_FLT_ONE] | f1s_q);
      FLOAT_TWO <= (brg_q[6:5] == bdc_pkg::MODE_INDEP) &&
                   (brg_q[bdc_pkg::BIT_FLT_TWO] | f2s_q);
      HANDSHAKE_OFF       <= brg_q[bdc_pkg::BIT_HS_OFF];
      BRIDGE_INPUT_SCHEME <= brg_q[6:5];
      FREEWHEEL_SIDE      <= brg_q[bdc_pkg::BIT_FW];
      {HS_SOURCE_CURRENT, HS_SINK_CURRENT} <= hsg_q;
      {LS_SOURCE_CURRENT, LS_SINK_CURRENT} <= lsg_q;
      GATE_FAULT_RESPONSE  <= mon_q[7:6];
      DRIVE_AND_BLANK_TIME <= mon_q[5:4];
      ADDED_DEAD_TIME      <= mon_q[3:1];
      GATE_PER_HALF_SHUTDOWN <= mon_q[bdc_pkg::BIT_IND] &&
        (brg_q[6:5] == bdc_pkg::MODE_INDEP ||
         brg_q[6:5] == bdc_pkg::MODE_SPLIT);
      OVERCURRENT_RESPONSE    <= ocf_q[7:6];
      OVERCURRENT_FILTER_TIME <= ocf_q[5:4];
      POST_FAULT_PULLDOWN     <= ocf_q[3:2];
      GATE_COMPARE_LEVEL      <= ocf_q[bdc_pkg::BIT_CMP_LVL];
      OC_PER_HALF_SHUTDOWN <= ocf_q[bdc_pkg::BIT_IND] &&
        (brg_q[6:5] == bdc_pkg::MODE_INDEP ||
         brg_q[6:5] == bdc_pkg::MODE_SPLIT);
      {HS_OVERCURRENT_LEVEL, LS_OVERCURRENT_LEVEL} <= ocl_q;
      LIMP_HOME_SEL        <= off_q[bdc_pkg::BIT_LIMP];
      CLEAR_LATCHED_FAULTS <= st_q == ST_CLEAR;
      FRAME_LENGTH_FAULT   <= len_flt_q;
      BAD_ADDRESS_FAULT    <= bad_address_fault_q;
    end
  end

  // checks
  sequence s_clear_issued;
    st_q == ST_CLEAR;
  endsequence

  a_clear_self_ends: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    s_clear_issued |-> ##2 !dev_q[bdc_pkg::BIT_CLR])
    else $error("clear bit did not return to zero");
  a_lock_holds_brg: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    locked |=> $stable(brg_q) || !$past(locked))
    else $error("locked bridge register changed");
  a_bad_len_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    frame_ev && !good_len |=> len_flt_q)
    else $error("short frame not flagged");
  a_bad_len_nowr: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    frame_ev && !good_len |=> $stable(brg_q) && $stable(hsg_q))
    else $error("bad frame changed a register");
  a_float_mode: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    brg_q[6:5] != bdc_pkg::MODE_INDEP |=> !FLOAT_ONE && !FLOAT_TWO)
    else $error("float asserted outside independent mode");
  a_src_one_sel: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    dev_q[bdc_pkg::BIT_SRC_ONE] |=>
      INPUT_ONE == $past(brg_q[bdc_pkg::BIT_SIN_ONE]))
    else $error("input one not from software bit");
  a_half_shut_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    brg_q[6:5] == 2'h1 |=> !GATE_PER_HALF_SHUTDOWN)
    else $error("per-half shutdown in wrong mode");
  a_outputs_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    !dev_q[bdc_pkg::BIT_OUTS_ON] |=> !GATE_OUTPUTS_ON)
    else $error("gate outputs on while disabled");
endmodule : bdc_regs

//--- verif/bdc_host.sv
// serial bus host model that frames accesses into the register bank
module bdc_host (
  output logic            SCLK,
  output logic            CS_B,
  output logic            SDI,
  input  wire logic       SDO
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 7.5;
  logic [15:0] rsp_word;
  event        rsp_ev;

  // idle: clock parked low, select high, data at its pulldown level
  initial
  begin
    SCLK = 1'b0;
    CS_B = 1'b1;
    SDI  = 1'b0;
    rsp_word = 16'h0000;
  end

  // one frame of n clocks, msb first; n other than 16 is deliberately bad
  task automatic xfer(input logic [15:0] w, input int n, input bit rep);
    logic [15:0] r;
    r = 16'h0000;
    CS_B = 1'b0;
    #(HALF);
    for (int i = n - 1; i >= 0; i--)
    begin
      SDI = (i < 16) ? w[i] : 1'b0;
      SCLK = 1'b1;
      #(HALF);
      SCLK = 1'b0;
      r = {r[14:0], SDO};
      #(HALF);
    end
    CS_B = 1'b1;
    SDI = 1'b0;
    if (rep)
    begin
      rsp_word = r;
      ->rsp_ev;
    end
    // select high time kept well above six system cycles
    #(80);
  endtask : xfer
endmodule : bdc_host

//--- verif/testbench.sv
// self-checking bench for the bridge driver control register bank
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       CLK_SYS, RST_B, SCLK, CS_B, SDI, SDO;
  logic       BRIDGE_INPUT_ONE, BRIDGE_INPUT_TWO, FLOAT_PIN_ONE;
  logic       FLOAT_PIN_TWO, GATE_OUTPUTS_ON, SPREAD_CLOCK_OFF;
  logic       INPUT_ONE, INPUT_TWO, FLOAT_ONE, FLOAT_TWO, HANDSHAKE_OFF;
  logic       FREEWHEEL_SIDE, GATE_PER_HALF_SHUTDOWN, GATE_COMPARE_LEVEL;
  logic       OC_PER_HALF_SHUTDOWN, LIMP_HOME_SEL, CLEAR_LATCHED_FAULTS;
  logic       FRAME_LENGTH_FAULT, BAD_ADDRESS_FAULT;
  logic [1:0] BRIDGE_INPUT_SCHEME, GATE_FAULT_RESPONSE, DRIVE_AND_BLANK_TIME;
  logic [1:0] OVERCURRENT_RESPONSE, OVERCURRENT_FILTER_TIME;
  logic [1:0] POST_FAULT_PULLDOWN;
  logic [2:0] ADDED_DEAD_TIME;
  logic [3:0] HS_SOURCE_CURRENT, HS_SINK_CURRENT, LS_SOURCE_CURRENT;
  logic [3:0] LS_SINK_CURRENT, HS_OVERCURRENT_LEVEL, LS_OVERCURRENT_LEVEL;
  logic [15:0] exp_q[$];
  logic [7:0]  stat_e = 8'hc0;
  int          fails = 0;
  int          total_checks = 0;
  int          clr_n = 0;
  logic [1:0]  brg_m = 2'b00;
  localparam logic [7:0] DEF [0:9] = '{bdc_pkg::RST_DEV_CTL,
    bdc_pkg::RST_BRG_CTL, bdc_pkg::RST_HS_GATE, bdc_pkg::RST_LS_GATE,
    bdc_pkg::RST_GATE_MON, bdc_pkg::RST_OC_CFG, bdc_pkg::RST_OC_LVL,
    bdc_pkg::RST_OFF_DIAG, bdc_pkg::RST_SUPPLY, bdc_pkg::RST_SHUNT};

  // register images rebuilt from the field outputs
  wire [7:0] img4 = {GATE_OUTPUTS_ON, SPREAD_CLOCK_OFF, 6'h00};
  wire [7:0] img5 = {HANDSHAKE_OFF, BRIDGE_INPUT_SCHEME, FREEWHEEL_SIDE, 4'h0};
  wire [7:0] img6 = {HS_SOURCE_CURRENT, HS_SINK_CURRENT};
  wire [7:0] img7 = {LS_SOURCE_CURRENT, LS_SINK_CURRENT};
  wire [7:0] img8 = {GATE_FAULT_RESPONSE, DRIVE_AND_BLANK_TIME,
                     ADDED_DEAD_TIME, GATE_PER_HALF_SHUTDOWN};
  wire [7:0] img9 = {OVERCURRENT_RESPONSE, OVERCURRENT_FILTER_TIME,
                     POST_FAULT_PULLDOWN, GATE_COMPARE_LEVEL,
                     OC_PER_HALF_SHUTDOWN};
  wire [7:0] imga = {HS_OVERCURRENT_LEVEL, LS_OVERCURRENT_LEVEL};
  wire [7:0] imgb = {LIMP_HOME_SEL, 7'h00};

  bdc_regs u_bdc_regs (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .SCLK(SCLK),
    .CS_B(CS_B), .SDI(SDI), .SDO(SDO), .BRIDGE_INPUT_ONE(BRIDGE_INPUT_ONE),
    .BRIDGE_INPUT_TWO(BRIDGE_INPUT_TWO), .FLOAT_PIN_ONE(FLOAT_PIN_ONE),
    .FLOAT_PIN_TWO(FLOAT_PIN_TWO), .GATE_OUTPUTS_ON(GATE_OUTPUTS_ON),
    .SPREAD_CLOCK_OFF(SPREAD_CLOCK_OFF), .INPUT_ONE(INPUT_ONE),
    .INPUT_TWO(INPUT_TWO), .FLOAT_ONE(FLOAT_ONE), .FLOAT_TWO(FLOAT_TWO),
    .HANDSHAKE_OFF(HANDSHAKE_OFF), .BRIDGE_INPUT_SCHEME(BRIDGE_INPUT_SCHEME),
    .FREEWHEEL_SIDE(FREEWHEEL_SIDE), .HS_SOURCE_CURRENT(HS_SOURCE_CURRENT),
    .HS_SINK_CURRENT(HS_SINK_CURRENT), .LS_SOURCE_CURRENT(LS_SOURCE_CURRENT),
    .LS_SINK_CURRENT(LS_SINK_CURRENT),
    .GATE_FAULT_RESPONSE(GATE_FAULT_RESPONSE),
    .DRIVE_AND_BLANK_TIME(DRIVE_AND_BLANK_TIME),
    .ADDED_DEAD_TIME(ADDED_DEAD_TIME),
    .GATE_PER_HALF_SHUTDOWN(GATE_PER_HALF_SHUTDOWN),
    .OVERCURRENT_RESPONSE(OVERCURRENT_RESPONSE),
    .OVERCURRENT_FILTER_TIME(OVERCURRENT_FILTER_TIME),
    .POST_FAULT_PULLDOWN(POST_FAULT_PULLDOWN),
    .GATE_COMPARE_LEVEL(GATE_COMPARE_LEVEL),
    .OC_PER_HALF_SHUTDOWN(OC_PER_HALF_SHUTDOWN),
    .HS_OVERCURRENT_LEVEL(HS_OVERCURRENT_LEVEL),
    .LS_OVERCURRENT_LEVEL(LS_OVERCURRENT_LEVEL),
    .LIMP_HOME_SEL(LIMP_HOME_SEL),
    .CLEAR_LATCHED_FAULTS(CLEAR_LATCHED_FAULTS),
    .FRAME_LENGTH_FAULT(FRAME_LENGTH_FAULT),
    .BAD_ADDRESS_FAULT(BAD_ADDRESS_FAULT));

  bdc_host u_host (.SCLK(SCLK), .CS_B(CS_B), .SDI(SDI), .SDO(SDO));

  // system clock, 8 ns period
  initial
  begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // write waits out the crossing plus the output register stage
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host.xfer({2'b00, a, d}, 16, 1'b0);
    repeat (8) @(posedge CLK_SYS);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back({stat_e, e});
    u_host.xfer({2'b01, a, 8'h00}, 16, 1'b1);
  endtask : rd

  task automatic field_chk(input logic [5:0] a, input logic [7:0] d);
    logic half_ok;
    // per-half shutdown only counts in schemes 00 and 11
    half_ok = (brg_m == 2'b00) || (brg_m == 2'b11);
    case (a)
      6'h04: check(img4, d & 8'hc0);
      6'h05:
      begin
        brg_m = d[6:5];
        check(img5, d & 8'hf0);
      end
      6'h06: check(img6, d);
      6'h07: check(img7, d);
      6'h08: check(img8, {d[7:1], d[0] & half_ok});
      6'h09: check(img9, {d[7:1], d[0] & half_ok});
      6'h0a: check(imga, d);
      6'h0b: check(imgb, d & 8'h80);
      default: ;
    endcase
  endtask : field_chk

  // oldest noted reply is compared whenever the host reports one
  always @(u_host.rsp_ev)
  begin
    if (exp_q.size() > 0)
      check(u_host.rsp_word, exp_q.pop_front());
    else
    begin
      fails++;
      $display("[ERR] %0t reply with nothing expected", $time);
    end
  end

  // clear request must be a single-cycle pulse
  always @(posedge CLK_SYS)
    if (CLEAR_LATCHED_FAULTS === 1'b1)
      clr_n++;

  // watchdog sized well past the expected run length
  initial
  begin
    #200000;
    fails++;
    $display("[ERR] %0t run did not complete", $time);
    tally_and_finish();
  end

  initial
  begin
    logic [7:0]  d;
    logic [15:0] s;
    logic [1:0]  m;
    RST_B = 1'b0;
    {BRIDGE_INPUT_ONE, BRIDGE_INPUT_TWO, FLOAT_PIN_ONE, FLOAT_PIN_TWO} = 4'h0;
    void'($urandom(32'h66d0));
    repeat (2) @(posedge CLK_SYS);
    #1 RST_B = 1'b1;
    repeat (3) @(posedge CLK_SYS);
    // defaults at the outputs and on readback
    for (logic [5:0] a = 6'h04; a <= 6'h0d; a++)
    begin
      field_chk(a, DEF[a - 6'h04]);
      rd(a, DEF[a - 6'h04]);
    end
    // random writes, field mirrors and readback, lock kept open
    for (int r = 0; r < 3; r++)
      for (logic [5:0] a = 6'h04; a <= 6'h0d; a++)
      begin
        d = 8'($urandom());
        if (a == 6'h04)
          d = {d[7:4], 4'b0110};
        if (a == 6'h0b)
          d[6:5] = 2'b00;
        wr(a, d);
        field_chk(a, d);
        rd(a, d);
      end
    // source selection and float gating across all four schemes
    for (int i = 0; i < 8; i++)
    begin
      s = 16'($urandom());
      m = 2'(i);
      wr(6'h04, {2'b00, s[1:0], 4'b0110});
      wr(6'h05, {1'b0, m, 1'b0, s[5:2]});
      @(posedge CLK_SYS);
      #1 {BRIDGE_INPUT_ONE, BRIDGE_INPUT_TWO, FLOAT_PIN_ONE, FLOAT_PIN_TWO}
        = s[9:6];
      repeat (6) @(posedge CLK_SYS);
      check(BRIDGE_INPUT_SCHEME, m);
      check({INPUT_ONE, INPUT_TWO},
            {s[1] ? s[5] : s[9], s[0] ? s[4] : s[8]});
      check({FLOAT_ONE, FLOAT_TWO},
            {2{m == 2'b00}} & (s[3:2] | s[7:6]));
    end
    // lock: writes ignored, odd codes ignored, unlock restores writes
    wr(6'h06, 8'h5a);
    wr(6'h04, 8'h0c);
    wr(6'h06, 8'h12);
    rd(6'h06, 8'h5a);
    wr(6'h04, 8'hca);
    check(img4, 8'h00);
    rd(6'h04, 8'h0c);
    wr(6'h06, 8'h33);
    rd(6'h06, 8'h5a);
    wr(6'h04, 8'h06);
    wr(6'h06, 8'h33);
    rd(6'h06, 8'h33);
    // short and long frames are dropped, bad address flagged
    u_host.xfer({2'b00, 6'h06, 8'h00}, 12, 1'b0);
    u_host.xfer({2'b00, 6'h06, 8'h11}, 17, 1'b0);
    repeat (8) @(posedge CLK_SYS);
    check(FRAME_LENGTH_FAULT, 1'b1);
    rd(6'h06, 8'h33);
    u_host.xfer({2'b01, 6'h3f, 8'h00}, 16, 1'b0);
    repeat (8) @(posedge CLK_SYS);
    check(BAD_ADDRESS_FAULT, 1'b1);
    rd(6'h02, 8'h03);
    // clear: one pulse, faults dropped, bit reads back zero
    clr_n = 0;
    wr(6'h04, 8'h07);
    check(16'(clr_n), 16'h0001);
    check({FRAME_LENGTH_FAULT, BAD_ADDRESS_FAULT}, 2'b00);
    rd(6'h04, 8'h06);
    wr(6'h02, 8'hff);
    rd(6'h02, 8'h00);
    repeat (4) @(posedge CLK_SYS);
    check(16'(exp_q.size()), 16'h0000);
    tally_and_finish();
  end
endmodule : testbench
